// ### sleep_ctrl_regs.sv
// Functional notes
// - bit 25 allows C6/C7 demotion to C3
// - bit 26 allows C3/C6/C7 demotion to C1
// - matching redirected port read becomes sleep request
// - base field reported as sleep-entry port
// - range field caps redirected depth C3/C6/C7
// - read/write counter of maximum-performance clocks
// - read/write counter of actual-performance clocks
// - bit 10 enables port-read redirection
`timescale 1ns/10ps
`default_nettype none
module sleep_ctrl_regs
  import sleep_regs_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [DATA_W-1:0]       s_axi_wdata,
  input  wire logic [STRB_W-1:0]       s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // core side
  input  wire logic                    max_perf_tick,
  input  wire logic                    actual_perf_tick,
  input  wire logic                    io_read_valid,
  input  wire logic [BASE_PORT_W-1:0]  io_read_port,
  output logic                         io_read_absorbed,
  input  wire logic                    sleep_req_valid,
  input  wire cstate_t                 sleep_req_state,
  output logic                         sleep_req_ready,
  input  wire logic                    uncore_demote_c3,
  input  wire logic                    uncore_demote_c1,
  output logic                         monitor_wait_request,
  output cstate_t                      monitor_wait_state,
  output logic [BASE_PORT_W-1:0]       redirect_port_base
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [DATA_W-1:0]       cfg_q;
  logic [DATA_W-1:0]       base_q;
  logic                    aw_hold_q;
  logic [WORD_W-1:0]       aw_word_q;
  logic                    w_hold_q;
  logic [DATA_W-1:0]       wdata_q;
  logic [STRB_W-1:0]       wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [DATA_W-1:0]       rdata_q;
  logic [1:0]              rresp_q;
  logic                    do_write;
  logic                    do_read;
  logic [WORD_W-1:0]       ar_word;
  logic                    redir_en;
  logic                    io_hit;
  logic [BASE_RANGE_W-1:0] range_code;
  cstate_t                 redirect_cap;
  cstate_t                 req_state;
  cstate_t                 demoted_state;
  logic                    sleep_q;
  cstate_t                 sleep_state_q;
  logic [BASE_PORT_W-1:0]  port_report_q;
  logic [DATA_W-1:0]       rd_mux;
  logic                    rd_hit;

  perf_count_if cif ();

  perf_clock_counters u_perf_clock_counters (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .cif      (cif.counters)
  );

  // ****************************************************************
  // write channel
  // ****************************************************************
  assign s_axi_awready = ce && !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_hold_q && !bvalid_q;
  assign do_write      = ce && aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      aw_word_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_word_q <= s_axi_awaddr[ADDR_W-1:2];
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= ZERO_WORD;
      wstrb_q  <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        unique case (aw_word_q)
          W_CFG_LO, W_CFG_HI, W_BASE_LO, W_BASE_HI,
          W_MPERF_LO, W_MPERF_HI, W_APERF_LO, W_APERF_HI: bresp_q <= RESP_OKAY;
          default: bresp_q <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // upper words hold nothing but reserved bits, so writes there are dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
    end else if (ce && do_write && aw_word_q == W_CFG_LO) begin
      cfg_q <= merge_strb(cfg_q, wdata_q, wstrb_q) & CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      base_q <= BASE_RESET;
    end else if (ce && do_write && aw_word_q == W_BASE_LO) begin
      base_q <= merge_strb(base_q, wdata_q, wstrb_q) & BASE_WRITE_MASK;
    end
  end

  assign cif.wdata = wdata_q;
  assign cif.wstrb = wstrb_q;
  // one process drives wr_lo, wr_hi and inc, so no bit of them has two drivers
  always_comb begin
    cif.wr_lo            = '0;
    cif.wr_hi            = '0;
    cif.inc              = '0;
    cif.wr_lo[CNT_MPERF] = do_write && aw_word_q == W_MPERF_LO;
    cif.wr_hi[CNT_MPERF] = do_write && aw_word_q == W_MPERF_HI;
    cif.wr_lo[CNT_APERF] = do_write && aw_word_q == W_APERF_LO;
    cif.wr_hi[CNT_APERF] = do_write && aw_word_q == W_APERF_HI;
    cif.inc[CNT_MPERF]   = max_perf_tick;
    cif.inc[CNT_APERF]   = actual_perf_tick;
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign s_axi_arready = ce && !rvalid_q;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign ar_word       = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_mux = ZERO_WORD;
    rd_hit = 1'b1;
    unique case (ar_word)
      W_CFG_LO:   rd_mux = cfg_q;
      W_BASE_LO:  rd_mux = base_q;
      W_CFG_HI, W_BASE_HI: rd_mux = ZERO_WORD;
      W_MPERF_LO: rd_mux = cif.count[CNT_MPERF][DATA_W-1:0];
      W_MPERF_HI: rd_mux = cif.count[CNT_MPERF][CNT_W-1:DATA_W];
      W_APERF_LO: rd_mux = cif.count[CNT_APERF][DATA_W-1:0];
      W_APERF_HI: rd_mux = cif.count[CNT_APERF][CNT_W-1:DATA_W];
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= ZERO_WORD;
      rresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ****************************************************************
  // port-read redirection and demotion
  // ****************************************************************
  assign redir_en   = cfg_q[CFG_REDIR_EN_BIT];
  assign range_code = base_q[BASE_RANGE_LSB +: BASE_RANGE_W];
  assign io_hit     = ce && redir_en && io_read_valid &&
                      io_read_port == base_q[BASE_PORT_LSB +: BASE_PORT_W];
  assign io_read_absorbed = io_hit;
  // a redirected read outranks a core request in the same cycle
  assign sleep_req_ready  = ce && !io_hit;

  // reserved range codes fall back to the shallowest cap
  always_comb begin
    unique case (range_code)
      RANGE_C6: redirect_cap = CST_C6;
      RANGE_C7: redirect_cap = CST_C7;
      default:  redirect_cap = CST_C3;
    endcase
  end

  assign req_state = io_hit ? redirect_cap : sleep_req_state;

  // demotion to C1 is the stronger hint and is checked first
  always_comb begin
    demoted_state = req_state;
    if (cfg_q[CFG_DEMOTE_C1_BIT] && uncore_demote_c1 &&
        (req_state == CST_C3 || req_state == CST_C6 || req_state == CST_C7)) begin
      demoted_state = CST_C1;
    end else if (cfg_q[CFG_DEMOTE_C3_BIT] && uncore_demote_c3 &&
                 (req_state == CST_C6 || req_state == CST_C7)) begin
      demoted_state = CST_C3;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_q       <= 1'b0;
      sleep_state_q <= CST_C1;
    end else if (ce) begin
      sleep_q <= io_hit || sleep_req_valid;
      if (io_hit || sleep_req_valid) begin
        sleep_state_q <= demoted_state;
      end
    end
  end

  assign monitor_wait_request = sleep_q;
  assign monitor_wait_state   = sleep_state_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_report_q <= '0;
    end else if (ce) begin
      port_report_q <= redir_en ? base_q[BASE_PORT_LSB +: BASE_PORT_W] : '0;
    end
  end

  assign redirect_port_base = port_report_q;

endmodule
`default_nettype wire

// ### sleep_regs_pkg.sv
`default_nettype none
package sleep_regs_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int WORD_W = 10;
  localparam int CNT_W  = 64;

  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_CFG   = 8'he2;
  localparam logic [7:0] IDX_BASE  = 8'he4;
  localparam logic [7:0] IDX_MPERF = 8'he7;
  localparam logic [7:0] IDX_APERF = 8'he8;

  // upper halves of the 64-bit registers sit in a second bank
  localparam logic [1:0] BANK_LO = 2'h0;
  localparam logic [1:0] BANK_HI = 2'h2;

  localparam logic [WORD_W-1:0] W_CFG_LO   = {BANK_LO, IDX_CFG};
  localparam logic [WORD_W-1:0] W_CFG_HI   = {BANK_HI, IDX_CFG};
  localparam logic [WORD_W-1:0] W_BASE_LO  = {BANK_LO, IDX_BASE};
  localparam logic [WORD_W-1:0] W_BASE_HI  = {BANK_HI, IDX_BASE};
  localparam logic [WORD_W-1:0] W_MPERF_LO = {BANK_LO, IDX_MPERF};
  localparam logic [WORD_W-1:0] W_MPERF_HI = {BANK_HI, IDX_MPERF};
  localparam logic [WORD_W-1:0] W_APERF_LO = {BANK_LO, IDX_APERF};
  localparam logic [WORD_W-1:0] W_APERF_HI = {BANK_HI, IDX_APERF};

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int CFG_REDIR_EN_BIT  = 10;
  localparam int CFG_DEMOTE_C3_BIT = 25;
  localparam int CFG_DEMOTE_C1_BIT = 26;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK  = 32'h0600_0400;
  localparam logic [DATA_W-1:0] BASE_WRITE_MASK = 32'h0007_ffff;
  localparam int BASE_PORT_LSB  = 0;
  localparam int BASE_PORT_W    = 16;
  localparam int BASE_RANGE_LSB = 16;
  localparam int BASE_RANGE_W   = 3;

  localparam logic [DATA_W-1:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BASE_RESET  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  COUNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

  localparam logic [BASE_RANGE_W-1:0] RANGE_C3 = 3'h0;
  localparam logic [BASE_RANGE_W-1:0] RANGE_C6 = 3'h1;
  localparam logic [BASE_RANGE_W-1:0] RANGE_C7 = 3'h2;

  // ****************************************************************
  // counters and sleep states
  // ****************************************************************
  localparam int NUM_CNT   = 2;
  localparam int CNT_MPERF = 0;
  localparam int CNT_APERF = 1;

  typedef enum logic [2:0] {
    CST_C1 = 3'h1,
    CST_C3 = 3'h2,
    CST_C6 = 3'h3,
    CST_C7 = 3'h4
  } cstate_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage
`default_nettype wire

// ### perf_count_if.sv
`timescale 1ns/10ps
`default_nettype none
interface perf_count_if;
  import sleep_regs_pkg::*;
  logic [NUM_CNT-1:0] wr_lo;
  logic [NUM_CNT-1:0] wr_hi;
  logic [NUM_CNT-1:0] inc;
  logic [DATA_W-1:0]  wdata;
  logic [STRB_W-1:0]  wstrb;
  logic [CNT_W-1:0]   count [NUM_CNT];

  modport regs (output wr_lo, output wr_hi, output inc, output wdata, output wstrb,
                input count);
  modport counters (input wr_lo, input wr_hi, input inc, input wdata, input wstrb,
                    output count);
endinterface
`default_nettype wire

// ### perf_clock_counters.sv
`timescale 1ns/10ps
`default_nettype none
module perf_clock_counters
  import sleep_regs_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   resetn,
  input  wire logic   ce,
  perf_count_if.counters cif
);

  // ****************************************************************
  // free-running 64-bit counters, software can load either half
  // ****************************************************************
  // a software write in the same cycle as a tick wins; the tick is lost,
  // which keeps the loaded value exact
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        cif.count[g] <= COUNT_RESET;
      end else if (ce) begin
        if (cif.wr_lo[g]) begin
          cif.count[g][DATA_W-1:0] <= merge_strb(cif.count[g][DATA_W-1:0],
                                                 cif.wdata, cif.wstrb);
        end else if (cif.wr_hi[g]) begin
          cif.count[g][CNT_W-1:DATA_W] <= merge_strb(cif.count[g][CNT_W-1:DATA_W],
                                                     cif.wdata, cif.wstrb);
        end else if (cif.inc[g]) begin
          cif.count[g] <= cif.count[g] + CNT_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### sleep_ctrl_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sleep_ctrl_regs_asserts
  import sleep_regs_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   resetn,
  input wire logic                   ce,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic                   io_read_valid,
  input wire logic [BASE_PORT_W-1:0] io_read_port,
  input wire logic                   io_read_absorbed,
  input wire logic                   sleep_req_valid,
  input wire logic                   sleep_req_ready,
  input wire logic                   monitor_wait_request,
  input wire logic [BASE_PORT_W-1:0] redirect_port_base
);
  // ****************************************************************
  // sleep path and bus handshakes
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_absorb_cause:
    assert property (io_read_absorbed |-> (ce && io_read_valid)
                     ##1 (redirect_port_base == $past(io_read_port)))
    else $error("absorbed read without matching port");
  a_absorb_blocks_core:
    assert property (io_read_absorbed |-> !sleep_req_ready)
    else $error("core request accepted beside absorbed read");
  a_absorb_issues_wait:
    assert property (io_read_absorbed |=> monitor_wait_request)
    else $error("absorbed read gave no sleep request");
  a_idle_no_wait:
    assert property (ce && !io_read_absorbed && !(sleep_req_valid && sleep_req_ready)
                     |=> !monitor_wait_request)
    else $error("sleep request without cause");
  a_freeze_readies:
    assert property (!ce |-> !s_axi_arready && !s_axi_awready && !sleep_req_ready)
    else $error("ready high while frozen");
  a_write_resp_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_no_write_in_resp:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered next cycle");
  a_read_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");

  c_absorb: cover property (io_read_absorbed);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_frozen: cover property (!ce);
endmodule

bind sleep_ctrl_regs sleep_ctrl_regs_asserts u_sleep_ctrl_regs_asserts (.*);
`default_nettype wire

// ### tb_sleep_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sleep_ctrl_regs;
  import sleep_regs_pkg::*;
  logic core_clk, resetn, ce, max_perf_tick, actual_perf_tick;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic io_read_valid, io_read_absorbed, sleep_req_valid, sleep_req_ready;
  logic uncore_demote_c3, uncore_demote_c1, monitor_wait_request;
  logic [BASE_PORT_W-1:0] io_read_port, redirect_port_base;
  cstate_t sleep_req_state, monitor_wait_state;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [ADDR_W-1:0] A_CFG = {W_CFG_LO, 2'h0};
  localparam logic [ADDR_W-1:0] A_BASE = {W_BASE_LO, 2'h0};
  // demotion table: config word, request, hints, expected state
  logic [31:0] dc[6] = '{32'h0, 32'h0200_0000, 32'h0400_0000, 32'h0600_0000, 32'h0200_0000,
                         32'h0200_0000};
  cstate_t ds[6] = '{CST_C7, CST_C6, CST_C3, CST_C7, CST_C7, CST_C3};
  cstate_t de[6] = '{CST_C7, CST_C3, CST_C1, CST_C1, CST_C7, CST_C3};
  logic [5:0] dh3 = 6'h2b;
  logic [5:0] dh1 = 6'h1d;
  cstate_t re[3] = '{CST_C3, CST_C6, CST_C7};

  sleep_ctrl_regs u_sleep_ctrl_regs (.*);

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task finish_test();
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic pa, pw, pb;
    pa = 1'h1;
    pw = 1'h1;
    pb = 1'h1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (pa || pw || pb) begin
      @(posedge core_clk);
      if (pa && s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pw && s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        pw = 1'h0;
      end
      if (pb && s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        pb = 1'h0;
        chk("bresp", s_axi_bresp, er);
      end
    end
    // idle edge: a following call must not raise bready in the step that lowered it
    @(posedge core_clk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic pa, pb;
    pa = 1'h1;
    pb = 1'h1;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    while (pa || pb) begin
      @(posedge core_clk);
      if (pa && s_axi_arready) begin
        s_axi_arvalid <= 1'h0;
        pa = 1'h0;
      end else if (!pa && s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        pb = 1'h0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
      end
    end
    // idle edge: a following call must not raise rready in the step that lowered it
    @(posedge core_clk);
  endtask

  // one cycle of core request, optionally with an i/o read beside it
  task pulse(input logic iov, input cstate_t st, input logic h3, input logic h1,
             input logic ea, input cstate_t es);
    io_read_valid    <= iov;
    sleep_req_valid  <= 1'h1;
    sleep_req_state  <= st;
    uncore_demote_c3 <= h3;
    uncore_demote_c1 <= h1;
    @(negedge core_clk);
    chk("absorbed", io_read_absorbed, ea);
    chk("req_ready", sleep_req_ready, !ea);
    @(posedge core_clk);
    io_read_valid   <= 1'h0;
    sleep_req_valid <= 1'h0;
    @(negedge core_clk);
    chk("wait_req", monitor_wait_request, 1'h1);
    chk("wait_state", monitor_wait_state, es);
    @(negedge core_clk);
    chk("wait_req_end", monitor_wait_request, 1'h0);
    @(posedge core_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset();
    rd(A_CFG, 32'h0, RESP_OKAY);
    rd(A_BASE, 32'h0, RESP_OKAY);
    rd({W_MPERF_LO, 2'h0}, 32'h0, RESP_OKAY);
    rd({W_APERF_HI, 2'h0}, 32'h0, RESP_OKAY);
    rd(12'h000, 32'h0, RESP_SLVERR);
  endtask

  task t_fields();
    wr(A_CFG, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(A_CFG, 32'h0600_0400, RESP_OKAY);
    wr({W_CFG_HI, 2'h0}, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd({W_CFG_HI, 2'h0}, 32'h0, RESP_OKAY);
    wr(A_BASE, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(A_BASE, 32'h0007_ffff, RESP_OKAY);
    wr(A_BASE, 32'h0000_1234, 4'h2, RESP_OKAY);
    rd(A_BASE, 32'h0007_12ff, RESP_OKAY);
    wr(12'h004, 32'h1, 4'hf, RESP_SLVERR);
  endtask

  // frozen cycles must not count
  task t_count();
    wr({W_MPERF_LO, 2'h0}, 32'hffff_fffe, 4'hf, RESP_OKAY);
    wr({W_APERF_HI, 2'h0}, 32'h5, 4'hf, RESP_OKAY);
    max_perf_tick <= 1'h1; actual_perf_tick <= 1'h1;
    repeat (4) @(posedge core_clk);
    ce <= 1'h0;
    repeat (2) @(posedge core_clk);
    max_perf_tick <= 1'h0; actual_perf_tick <= 1'h0; ce <= 1'h1;
    @(posedge core_clk);
    rd({W_MPERF_LO, 2'h0}, 32'h2, RESP_OKAY);
    rd({W_MPERF_HI, 2'h0}, 32'h1, RESP_OKAY);
    rd({W_APERF_LO, 2'h0}, 32'h4, RESP_OKAY);
    rd({W_APERF_HI, 2'h0}, 32'h5, RESP_OKAY);
  endtask

  task t_redirect();
    wr(A_CFG, 32'h0, 4'hf, RESP_OKAY);
    wr(A_BASE, 32'h0000_0415, 4'hf, RESP_OKAY);
    io_read_port <= 16'h0415;
    @(negedge core_clk);
    chk("port_off", redirect_port_base, 16'h0);
    @(posedge core_clk);
    pulse(1'h1, CST_C7, 1'h0, 1'h0, 1'h0, CST_C7);
    wr(A_CFG, 32'h0000_0400, 4'hf, RESP_OKAY);
    @(negedge core_clk);
    chk("port_on", redirect_port_base, 16'h0415);
    @(posedge core_clk);
    for (int r = 0; r < 3; r++) begin
      wr(A_BASE, {13'h0, r[2:0], 16'h0415}, 4'hf, RESP_OKAY);
      pulse(1'h1, CST_C1, 1'h0, 1'h0, 1'h1, re[r]);
    end
    io_read_port <= 16'h0416;
    pulse(1'h1, CST_C6, 1'h0, 1'h0, 1'h0, CST_C6);
  endtask

  task t_demote();
    for (int i = 0; i < 6; i++) begin
      wr(A_CFG, dc[i], 4'hf, RESP_OKAY);
      pulse(1'h0, ds[i], dh3[i], dh1[i], 1'h0, de[i]);
    end
  endtask

  initial begin
    resetn = 1'h0; ce = 1'h1; max_perf_tick = 1'h0; actual_perf_tick = 1'h0;
    s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0; s_axi_rready = 1'h0; s_axi_awaddr = 12'h0; s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; io_read_valid = 1'h0; io_read_port = 16'h0;
    sleep_req_valid = 1'h0; sleep_req_state = CST_C1;
    uncore_demote_c3 = 1'h0; uncore_demote_c1 = 1'h0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_fields();
    t_count();
    t_redirect();
    t_demote();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
